// ==== samc_core.sv ====
`timescale 1ns/1ps
`include "samc_defs.svh"

module samc_core
  import samc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in_line,
  input wire logic lsb_first_trigger_n,
  input wire logic eight_input_variant,
  input wire logic comparator_above,
  input wire logic positive_below_negative,
  output logic serial_out,
  output logic serial_out_oe,
  output logic conversion_active_flag,
  output logic conversion_active_oe,
  output logic [3:0] mux_positive_select,
  output logic [3:0] mux_negative_select,
  output logic [7:0] ladder_trial_code
);

  // Positive input of the selected configuration.
  function automatic logic [3:0] samc_positive(input logic eight, input logic [3:0] addr);
    logic sgl;
    logic odd;
    logic sel1;
    logic sel0;
    sgl = addr[3];
    odd = addr[2];
    sel1 = addr[1];
    sel0 = addr[0];
    if (eight) begin
      samc_positive = {1'b0, sel1, sel0, odd};
    end else if (sgl) begin
      // Single-ended and differential four-input modes share the positive member.
      samc_positive = {2'b00, sel1, odd};
    end else begin
      samc_positive = {2'b00, sel1, odd};
    end
  endfunction : samc_positive

  // Negative input of the selected configuration.
  function automatic logic [3:0] samc_negative(input logic eight, input logic [3:0] addr);
    logic sgl;
    logic odd;
    logic sel1;
    logic sel0;
    sgl = addr[3];
    odd = addr[2];
    sel1 = addr[1];
    sel0 = addr[0];
    if (eight && sgl) begin
      samc_negative = `SAMC_SEL_COMMON;
    end else if (eight) begin
      samc_negative = {1'b0, sel1, sel0, ~odd};
    end else if (sgl) begin
      samc_negative = `SAMC_SEL_GROUND;
    end else begin
      samc_negative = {2'b00, sel1, ~odd};
    end
  endfunction : samc_negative

  // Two-stage synchronisers for every pin from outside the mclk domain.
  logic [1:0] cs_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic [1:0] trig_sync;
  logic [1:0] var_sync;
  logic [1:0] cmp_sync;
  logic [1:0] neg_sync;
  logic clk_prev;

  // Next values of the synchroniser stages and the edge detector.
  logic [1:0] next_cs_sync;
  logic [1:0] next_clk_sync;
  logic [1:0] next_din_sync;
  logic [1:0] next_trig_sync;
  logic [1:0] next_var_sync;
  logic [1:0] next_cmp_sync;
  logic [1:0] next_neg_sync;
  logic next_clk_prev;

  // The first stage of each pair is read only by its second stage.
  always_comb begin
    next_cs_sync = {cs_sync[0], chip_select_n};
    next_clk_sync = {clk_sync[0], serial_clock};
    next_din_sync = {din_sync[0], serial_in_line};
    next_trig_sync = {trig_sync[0], lsb_first_trigger_n};
    next_var_sync = {var_sync[0], eight_input_variant};
    next_cmp_sync = {cmp_sync[0], comparator_above};
    next_neg_sync = {neg_sync[0], positive_below_negative};
    next_clk_prev = clk_sync[1];
  end

  // Registers of the synchronisers; reset levels match the idle pins.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync <= 2'b11;
      clk_sync <= 2'b00;
      din_sync <= 2'b00;
      trig_sync <= 2'b11;
      var_sync <= 2'b00;
      cmp_sync <= 2'b00;
      neg_sync <= 2'b00;
      clk_prev <= 1'b0;
    end else begin
      cs_sync <= next_cs_sync;
      clk_sync <= next_clk_sync;
      din_sync <= next_din_sync;
      trig_sync <= next_trig_sync;
      var_sync <= next_var_sync;
      cmp_sync <= next_cmp_sync;
      neg_sync <= next_neg_sync;
      clk_prev <= next_clk_prev;
    end
  end

  // Synchronised levels and serial clock edges found by the mclk domain.
  logic cs_high;
  logic din;
  logic trig_n;
  logic clk_rise;
  logic clk_fall;
  logic bit_decision;

  assign cs_high = cs_sync[1];
  assign din = din_sync[1];
  assign trig_n = trig_sync[1];
  // Serial clock edges show here two mclk cycles after the pin moves.
  assign clk_rise = clk_sync[1] && !clk_prev;
  assign clk_fall = !clk_sync[1] && clk_prev;
  // A reversed input pair forces every decided bit to zero.
  assign bit_decision = cmp_sync[1] && !neg_sync[1];

  // Frame state.
  samc_state_t state;
  samc_state_t next_state;
  logic [2:0] addr_count;
  logic [2:0] next_addr_count;
  logic [3:0] addr_shift;
  logic [3:0] next_addr_shift;
  logic eight_mode;
  logic next_eight_mode;
  logic [2:0] bit_index;
  logic [2:0] next_bit_index;
  logic [7:0] result_code;
  logic [7:0] next_result_code;
  logic [8:0] out_shift;
  logic [8:0] next_out_shift;

  // Next values of the output registers.
  logic next_serial_out;
  logic next_serial_out_oe;
  logic next_active;
  logic next_active_oe;
  logic [3:0] next_pos_sel;
  logic [3:0] next_neg_sel;
  logic [7:0] next_trial;

  // Next-state logic for addressing, settling, conversion and readback.
  always_comb begin
    logic [3:0] full_addr;
    logic [2:0] addr_len;
    full_addr = addr_shift;
    addr_len = `SAMC_ADDR_LEN_EIGHT;
    // Every value holds unless a branch below moves it.
    next_state = state;
    next_addr_count = addr_count;
    next_addr_shift = addr_shift;
    next_eight_mode = eight_mode;
    next_bit_index = bit_index;
    next_result_code = result_code;
    next_out_shift = out_shift;
    next_serial_out = serial_out;
    next_serial_out_oe = serial_out_oe;
    next_active = conversion_active_flag;
    next_active_oe = conversion_active_oe;
    next_pos_sel = mux_positive_select;
    next_neg_sel = mux_negative_select;
    next_trial = ladder_trial_code;
    if (cs_high) begin
      // Chip select high wipes the frame and floats both outputs.
      next_state = SAMC_IDLE;
      next_addr_count = 3'h0;
      next_addr_shift = `SAMC_ADDR_RESET;
      next_eight_mode = 1'b0;
      next_bit_index = `SAMC_MSB_INDEX;
      next_result_code = `SAMC_CODE_RESET;
      next_out_shift = `SAMC_SHIFT_RESET;
      next_serial_out = 1'b0;
      next_serial_out_oe = 1'b0;
      next_active = 1'b0;
      next_active_oe = 1'b0;
      next_pos_sel = `SAMC_SEL_NONE;
      next_neg_sel = `SAMC_SEL_NONE;
      next_trial = `SAMC_TRIAL_RESET;
    end else begin
      case (state)
        SAMC_IDLE: begin
          // Low levels before the start bit are discarded.
          if (clk_rise && din) begin
            next_state = SAMC_ADDR;
            next_addr_count = 3'h0;
            // The variant strap is taken once per frame, at the start bit.
            next_eight_mode = var_sync[1];
          end
        end
        SAMC_ADDR: begin
          // Address bits arrive in order: mode, parity, upper select, lower select.
          if (clk_rise) begin
            next_addr_shift = {addr_shift[2:0], din};
            next_addr_count = addr_count + 3'h1;
            // Four-input parts take one address bit fewer.
            if (!eight_mode) begin
              addr_len = `SAMC_ADDR_LEN_FOUR;
            end
            // A complete word selects the inputs and opens the conversion.
            if (next_addr_count == addr_len) begin
              if (eight_mode) begin
                full_addr = next_addr_shift;
              end else begin
                full_addr = {next_addr_shift[2:0], 1'b1};
              end
              next_addr_shift = full_addr;
              next_pos_sel = samc_positive(eight_mode, full_addr);
              next_neg_sel = samc_negative(eight_mode, full_addr);
              next_active = 1'b1;
              next_active_oe = 1'b1;
              next_state = SAMC_SETTLE;
            end
          end
        end
        SAMC_SETTLE: begin
          // One full clock period of leading low while the multiplexer settles.
          if (clk_fall) begin
            next_serial_out_oe = 1'b1;
            next_serial_out = 1'b0;
            next_bit_index = `SAMC_MSB_INDEX;
            // The trial restarts at mid-scale for the most significant bit.
            next_trial = `SAMC_TRIAL_RESET;
            next_state = SAMC_CONV;
          end
        end
        SAMC_CONV: begin
          // Each falling edge decides one bit and drives it out at once.
          if (clk_fall) begin
            next_result_code[bit_index] = bit_decision;
            next_serial_out = bit_decision;
            // After bit 0 the result is parked for the LSB-first readback.
            if (bit_index == 3'h0) begin
              next_out_shift = {1'b0, next_result_code};
              next_trial = next_result_code;
              next_state = SAMC_LSB;
            end else begin
              // The next trial keeps the decided bits and tries the next lower one.
              next_trial = next_result_code | (8'h01 << (bit_index - 3'h1));
              next_bit_index = bit_index - 3'h1;
            end
          end
        end
        SAMC_LSB: begin
          // The first falling edge here closes the eight conversion periods.
          if (clk_fall) begin
            next_active = 1'b0;
            // Bit 0 already went out, so the stream resumes with bit 1.
            if (!eight_mode || !trig_n) begin
              next_out_shift = {1'b0, out_shift[8:1]};
              next_serial_out = out_shift[1];
            end else begin
              // A high trigger on the eight-input part parks bit 0 on the line.
              next_serial_out = out_shift[0];
            end
          end
        end
        default: begin
          // An unused state code falls back to idle.
          next_state = SAMC_IDLE;
        end
      endcase
    end
  end

  // Registers of the frame state; all outputs come straight from here.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SAMC_IDLE;
      addr_count <= 3'h0;
      addr_shift <= `SAMC_ADDR_RESET;
      eight_mode <= 1'b0;
      bit_index <= `SAMC_MSB_INDEX;
      result_code <= `SAMC_CODE_RESET;
      out_shift <= `SAMC_SHIFT_RESET;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      conversion_active_flag <= 1'b0;
      conversion_active_oe <= 1'b0;
      mux_positive_select <= `SAMC_SEL_NONE;
      mux_negative_select <= `SAMC_SEL_NONE;
      ladder_trial_code <= `SAMC_TRIAL_RESET;
    end else begin
      state <= next_state;
      addr_count <= next_addr_count;
      addr_shift <= next_addr_shift;
      eight_mode <= next_eight_mode;
      bit_index <= next_bit_index;
      result_code <= next_result_code;
      out_shift <= next_out_shift;
      serial_out <= next_serial_out;
      serial_out_oe <= next_serial_out_oe;
      conversion_active_flag <= next_active;
      conversion_active_oe <= next_active_oe;
      mux_positive_select <= next_pos_sel;
      mux_negative_select <= next_neg_sel;
      ladder_trial_code <= next_trial;
    end
  end

endmodule : samc_core

// ==== samc_core_checker.sv ====
`timescale 1ns/1ps
// Watches the converter pins for slips in frame sequencing.
module samc_core_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic lsb_first_trigger_n,
  input wire logic eight_input_variant,
  input wire logic positive_below_negative,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic conversion_active_flag,
  input wire logic conversion_active_oe,
  input wire logic [3:0] mux_positive_select,
  input wire logic [3:0] mux_negative_select,
  input wire logic [7:0] ladder_trial_code
);
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic sclk_d;
  logic next_sclk_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Counts serial clock rises while the flag is high.
  always_comb begin
    next_sclk_d = serial_clock;
    next_rise_cnt = rise_cnt;
    if (!conversion_active_flag) next_rise_cnt = 4'h0;
    else if (serial_clock && !sclk_d) next_rise_cnt = rise_cnt + 4'h1;
  end
  // Registers the counter state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt <= 4'h0;
      sclk_d <= 1'b0;
    end else begin
      rise_cnt <= next_rise_cnt;
      sclk_d <= next_sclk_d;
    end
  end
  sequence s_cs_idle; chip_select_n [*4]; endsequence
  sequence s_start; $rose(conversion_active_flag); endsequence
  property p_clear; s_cs_idle |=> !serial_out_oe && !conversion_active_oe && !serial_out
    && !conversion_active_flag && ladder_trial_code == 8'h80 && mux_positive_select == 4'hf;
  endproperty
  property p_start; s_start |-> conversion_active_oe && !serial_out_oe
    && mux_positive_select != 4'hf; endproperty
  property p_settle; $rose(serial_out_oe) |-> !serial_out && conversion_active_flag; endproperty
  property p_hold_sel; conversion_active_flag && $past(conversion_active_flag)
    |-> $stable(mux_positive_select) && $stable(mux_negative_select); endproperty
  property p_flag_len; $fell(conversion_active_flag) && !chip_select_n |-> rise_cnt == 4'h9;
  endproperty
  property p_below; serial_out_oe && conversion_active_flag && positive_below_negative
    && $past(positive_below_negative, 8) |-> !serial_out; endproperty
  property p_lsb_hold; eight_input_variant && lsb_first_trigger_n && $past(lsb_first_trigger_n, 4)
    && !conversion_active_flag && serial_out_oe && $past(serial_out_oe) |-> $stable(serial_out);
  endproperty
  property p_four; (s_start and !eight_input_variant) |-> mux_positive_select < 4'h4;
  endproperty
  property p_oe_pair; serial_out_oe |-> conversion_active_oe; endproperty
  a_clear: assert property (p_clear) else $error("outputs not cleared");
  a_start: assert property (p_start) else $error("bad conversion start");
  a_settle: assert property (p_settle) else $error("no low settle bit");
  a_hold_sel: assert property (p_hold_sel) else $error("selects moved");
  a_flag_len: assert property (p_flag_len) else $error("flag length wrong");
  a_below: assert property (p_below) else $error("nonzero bit");
  a_lsb_hold: assert property (p_lsb_hold) else $error("lsb not held");
  a_four: assert property (p_four) else $error("four input channel");
  a_oe_pair: assert property (p_oe_pair) else $error("data driven early");
endmodule : samc_core_checker

bind samc_core samc_core_checker chk_u (.mclk(mclk), .rst_b(rst_b),
  .chip_select_n(chip_select_n), .serial_clock(serial_clock),
  .lsb_first_trigger_n(lsb_first_trigger_n), .eight_input_variant(eight_input_variant),
  .positive_below_negative(positive_below_negative), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .conversion_active_flag(conversion_active_flag),
  .conversion_active_oe(conversion_active_oe), .mux_positive_select(mux_positive_select),
  .mux_negative_select(mux_negative_select), .ladder_trial_code(ladder_trial_code));

// ==== samc_defs.svh ====
`ifndef SAMC_DEFS_SVH
`define SAMC_DEFS_SVH

// Address word lengths after the start bit, per variant.
`define SAMC_ADDR_LEN_EIGHT 3'h4
`define SAMC_ADDR_LEN_FOUR 3'h3

// Result width and the index of its most significant bit.
`define SAMC_RESULT_BITS 8
`define SAMC_MSB_INDEX 3'h7

// Width of the output shift register used for the LSB-first readback.
`define SAMC_OUT_SHIFT_BITS 9

// Codes on the multiplexer select outputs besides channels 0 to 7.
`define SAMC_SEL_COMMON 4'h8
`define SAMC_SEL_GROUND 4'h9
`define SAMC_SEL_NONE 4'hf

// Reset values.
`define SAMC_CODE_RESET 8'h00
`define SAMC_TRIAL_RESET 8'h80
`define SAMC_ADDR_RESET 4'h0
`define SAMC_SHIFT_RESET 9'h000

`endif

// ==== samc_host_model.sv ====
`timescale 1ns/1ps
// Host controller plus analog front end facing the converter.
module samc_host_model (
  input wire logic mclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic conversion_active_flag,
  input wire logic [7:0] ladder_trial_code,
  output logic chip_select_n = 1'b1,
  output logic serial_clock = 1'b0,
  output logic serial_in_line = 1'b0,
  output logic lsb_first_trigger_n = 1'b1,
  output logic comparator_above
);
  logic [7:0] vin = 8'h00;
  logic so_k [0:31];
  logic fl_k [0:31];
  logic oe_k [0:31];
  // The comparator sees the input at or above the ladder trial.
  assign comparator_above = vin >= ladder_trial_code;
  // One frame: two idle zeros, start bit, address word, then clocks until n periods.
  task automatic frame(input logic [3:0] adr, input int na, input int tl, input int n);
    int k;
    @(posedge mclk);
    chip_select_n <= 1'b0;
    lsb_first_trigger_n <= tl > 0;
    for (int p = 0; p < n + 2; p++) begin
      k = p - 2;
      serial_clock <= 1'b0;
      serial_in_line <= k == 0 || (k > 0 && k <= na && adr[4 - k]) || (k > na && k[0]);
      repeat (4) @(posedge mclk);
      serial_clock <= 1'b1;
      if (k == tl) lsb_first_trigger_n <= 1'b0;
      repeat (2) @(posedge mclk);
      if (k >= 0) begin
        so_k[k] = serial_out;
        fl_k[k] = conversion_active_flag;
        oe_k[k] = serial_out_oe;
      end
      repeat (2) @(posedge mclk);
    end
    serial_clock <= 1'b0;
    chip_select_n <= 1'b1;
    serial_in_line <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : frame
endmodule : samc_host_model

// ==== samc_pkg.sv ====
package samc_pkg;

  // Phases of one chip-select frame.
  typedef enum logic [2:0] {
    SAMC_IDLE = 3'b000,
    SAMC_ADDR = 3'b001,
    SAMC_SETTLE = 3'b010,
    SAMC_CONV = 3'b011,
    SAMC_LSB = 3'b100
  } samc_state_t;

endpackage : samc_pkg

// ==== serial_adc_mux_control_tb_top.sv ====
`timescale 1ns/1ps
// Runs host frames against the converter and judges its answers.
module serial_adc_mux_control_tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic eight_input_variant = 1'b0;
  logic positive_below_negative = 1'b0;
  wire chip_select_n, serial_clock, serial_in_line, lsb_first_trigger_n, comparator_above;
  wire serial_out, serial_out_oe, conversion_active_flag, conversion_active_oe;
  wire [3:0] mux_positive_select, mux_negative_select;
  wire [7:0] ladder_trial_code;
  logic [3:0] pos_l;
  logic [3:0] neg_l;
  int fails = 0;
  int n_checks = 0;
  samc_core dut_u (.mclk(mclk), .rst_b(rst_b), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in_line(serial_in_line),
    .lsb_first_trigger_n(lsb_first_trigger_n), .eight_input_variant(eight_input_variant),
    .comparator_above(comparator_above), .positive_below_negative(positive_below_negative),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conversion_active_flag(conversion_active_flag), .conversion_active_oe(conversion_active_oe),
    .mux_positive_select(mux_positive_select), .mux_negative_select(mux_negative_select),
    .ladder_trial_code(ladder_trial_code));
  samc_host_model pm_u (.mclk(mclk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conversion_active_flag(conversion_active_flag), .ladder_trial_code(ladder_trial_code),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_in_line(serial_in_line),
    .lsb_first_trigger_n(lsb_first_trigger_n), .comparator_above(comparator_above));
  // Clock at 20 MHz.
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Keeps the selects seen while a conversion runs.
  always @(negedge mclk) begin
    if (conversion_active_flag === 1'b1) begin
      pos_l = mux_positive_select;
      neg_l = mux_negative_select;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Compares a captured frame; s is the period holding the second LSB-first bit.
  // d moves a four-input frame, one address bit shorter, onto the eight-input periods.
  task automatic chk_stream(input logic [7:0] v, input int s, input int d);
    logic e;
    int j;
    for (int k = 0; k < 26; k++) begin
      j = k + d;
      if (j >= 6 && j <= 13) e = v[13 - j];
      else if (j >= 14 && j < s) e = v[0];
      else if (j >= s && j <= s + 6) e = v[j - s + 1];
      else e = 1'b0;
      chk_bit(pm_u.so_k[k], e, "data bit");
      chk_bit(pm_u.fl_k[k], j >= 5 && j <= 13, "active flag");
      chk_bit(pm_u.oe_k[k], j >= 5, "data enable");
    end
  endtask : chk_stream
  // Every address code on both variants, aborted mid-conversion.
  task automatic t_mux_table();
    logic [3:0] ep;
    logic [3:0] en;
    for (int v = 0; v < 2; v++) begin
      for (int a = 0; a < 16; a++) begin
        @(posedge mclk);
        eight_input_variant <= v[0];
        pos_l = 4'hf;
        neg_l = 4'hf;
        pm_u.frame(a[3:0], 3 + v, 0, 6);
        ep = v ? {1'b0, a[1], a[0], a[2]} : {2'b00, a[1], a[2]};
        en = v ? (a[3] ? 4'h8 : {1'b0, a[1], a[0], ~a[2]}) : (a[3] ? 4'h9 : {2'b00, a[1], ~a[2]});
        chk({ep, en}, {pos_l, neg_l}, "selects");
        chk({serial_out_oe, conversion_active_oe, conversion_active_flag, serial_out,
          mux_positive_select}, 8'h0f, "cleared outputs");
        chk(ladder_trial_code, 8'h80, "cleared trial");
      end
    end
    $display("mux table done");
  endtask : t_mux_table
  // Eight-input conversion with the readback trigger held high for a while.
  task automatic t_conv8();
    @(posedge mclk);
    eight_input_variant <= 1'b1;
    pm_u.vin <= 8'h6d;
    pm_u.frame(4'h8, 4, 15, 26);
    chk_stream(8'h6d, 16, 0);
    $display("eight input conversion done");
  endtask : t_conv8
  // Four-input conversion streams LSB first with the trigger ignored.
  task automatic t_conv4();
    @(posedge mclk);
    eight_input_variant <= 1'b0;
    pm_u.vin <= 8'hb2;
    pm_u.frame(4'h8, 3, 15, 26);
    chk_stream(8'hb2, 14, 1);
    $display("four input conversion done");
  endtask : t_conv4
  // Positive input below negative input gives all zeros.
  task automatic t_below();
    @(posedge mclk);
    eight_input_variant <= 1'b1;
    positive_below_negative <= 1'b1;
    pm_u.vin <= 8'hff;
    pm_u.frame(4'h0, 4, 0, 26);
    chk_stream(8'h00, 14, 0);
    positive_below_negative <= 1'b0;
    $display("below test done");
  endtask : t_below
  // Main sequence.
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_mux_table();
    t_conv8();
    t_conv4();
    t_below();
    wrap_up();
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end
endmodule : serial_adc_mux_control_tb_top
